// ---- hw/pdtx_pkg.sv ----
/*
  pdtx_pkg: constants, types and register map of the pd transmit-control policy.
  assumes a 32-bit apb master and one 100 MHz clock domain.
*/
// Overview of operation
// - with no busy option, a busy line aborts the queued packet and its retries
// - busy_retry_enable retries on busy, up to retry_limit times
// - retries exhausted under busy_retry_enable report send_failed_flag, not aborted
// - hard reset aborts; cable reset aborts cable-plug sop packets when enabled
// - good new non-ping non-goodcrc rx packet of matching sop aborts
// - software abort bit in tx_control_b aborts at any time
// - rx sop aborts non-sop tx unless primary_frame_abort_scope is set
// - auto goodcrc for soft reset ignores busy unless special disable set
// - with special disable set, idle_wait_enable also governs that ack
// - idle_wait_enable holds the packet until the line is idle, then sends
// - idle wait takes priority over retry on busy
// - auto_reply_enable enables hardware goodcrc and bist error count replies
// - auto_reply_enable cleared means no hardware retries, retry_limit ignored
// - queue_fifo_enable selects fifo or buffer access to the tx queue
// - raw_processing_enable selects raw or automatic data processing
// - tx_control_a is 8 bits, resets to zero, top bit reserved read-only
// - retry_limit of zero disables hardware retry
package pdtx_pkg;
  localparam logic [15:0] IDX_CTL_A  = 16'h1a00;
  localparam logic [15:0] IDX_PARM_C = 16'h1a02;
  localparam logic [15:0] IDX_CTL_B  = 16'h1c00;
  localparam logic [15:0] IDX_STAT   = 16'h1c01;
  localparam logic [15:0] IDX_IRQ_ST = 16'h1c02;
  localparam logic [15:0] IDX_IRQ_MK = 16'h1c03;
  localparam logic [31:0] ADDR_CTL_A  = {14'h0000, IDX_CTL_A, 2'b00};
  localparam logic [31:0] ADDR_PARM_C = {14'h0000, IDX_PARM_C, 2'b00};
  localparam logic [31:0] ADDR_CTL_B  = {14'h0000, IDX_CTL_B, 2'b00};
  localparam logic [31:0] ADDR_STAT   = {14'h0000, IDX_STAT, 2'b00};
  localparam logic [31:0] ADDR_IRQ_ST = {14'h0000, IDX_IRQ_ST, 2'b00};
  localparam logic [31:0] ADDR_IRQ_MK = {14'h0000, IDX_IRQ_MK, 2'b00};
  localparam logic [7:0]  CTL_A_RST   = 8'h00;
  localparam logic [7:0]  CTL_A_WMASK = 8'h7f;
  localparam logic [7:0]  PARM_C_WMASK = 8'hfc;
  localparam int CA_RAW = 0;
  localparam int CA_FIFO = 1;
  localparam int CA_AUTO = 2;
  localparam int CA_IDLE = 3;
  localparam int CA_SRDIS = 4;
  localparam int CA_SCOPE = 5;
  localparam int CA_RETRY = 6;
  localparam int CB_GO = 0;
  localparam int CB_ABORT = 1;
  localparam int CB_SOP = 2;
  localparam int CB_CBL = 5;
  localparam int CB_EXP = 6;
  localparam int PC_RETRY = 4;
  localparam int IQ_DONE = 0;
  localparam int IQ_ABRT = 1;
  localparam int IQ_FAIL = 2;
  localparam logic [2:0] SOP_PRIMARY = 3'h0;
  localparam logic [2:0] SOP_LAST_CABLE = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARB  = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b011,
    ST_ACK  = 3'b100
  } pdtx_state_t;
  typedef struct packed {
    logic [2:0] sop;
    logic       good;
    logic       dup;
    logic       ping;
    logic       goodcrc;
  } pdtx_rx_t;
endpackage

// ---- hw/pdtx_ctrl.sv ----
/*
  pdtx_ctrl: transmit-control policy with apb registers and interrupt.
  assumes rx decode, phy and ack timer outside, all on core_clk.
*/
`timescale 1ns/100ps
module pdtx_ctrl
  import pdtx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        line_busy,
  input  wire logic        rx_valid,
  input  wire pdtx_rx_t    rx_pkt,
  input  wire logic        hard_reset_rx,
  input  wire logic        cable_reset_rx,
  input  wire logic        ack_req,
  input  wire logic        ack_for_soft_reset,
  input  wire logic        phy_done,
  input  wire logic        ack_rx,
  input  wire logic        ack_timeout,
  output logic             phy_start,
  output logic             phy_is_ack,
  output logic             tx_drive,
  output logic             tx_active,
  output logic             queue_fifo_mode,
  output logic             raw_mode,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // register state
  pdtx_state_t state_r, state_nxt;
  logic [7:0] ctl_a_r;
  logic [7:0] parm_c_r;
  logic [7:0] ctl_b_r;
  logic [2:0] irq_st_r, irq_mk_r;
  logic [2:0] cnt_r, cnt_nxt;
  logic       go_pend_r, ack_pend_r, ack_sr_r;
  logic       cur_ack_r, cur_sr_r;
  logic [7:0] prdata_r;
  logic       pslverr_r;
  logic       phy_start_r;

  function automatic logic is_cable(input logic [2:0] s);
    is_cable = (s != SOP_PRIMARY) && (s <= SOP_LAST_CABLE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire        setup_ph = psel & ~penable;
  wire        wr_en    = psel & penable & pwrite;
  wire        hit_a    = paddr == ADDR_CTL_A;
  wire        hit_c    = paddr == ADDR_PARM_C;
  wire        hit_b    = paddr == ADDR_CTL_B;
  wire        hit_s    = paddr == ADDR_STAT;
  wire        hit_is   = paddr == ADDR_IRQ_ST;
  wire        hit_im   = paddr == ADDR_IRQ_MK;
  wire        hit_any  = hit_a | hit_c | hit_b | hit_s | hit_is | hit_im;
  wire        wr_b     = wr_en & hit_b;
  wire        sw_go    = wr_b & pwdata[CB_GO];
  wire        sw_abort = wr_b & pwdata[CB_ABORT];
  wire [7:0]  stat_v   = {1'b0, cnt_r, state_r, tx_active};
  wire [7:0]  rd_mux   = hit_a  ? ctl_a_r :
                         hit_c  ? parm_c_r :
                         hit_b  ? ctl_b_r :
                         hit_s  ? stat_v :
                         hit_is ? {5'h00, irq_st_r} :
                         hit_im ? {5'h00, irq_mk_r} : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // control fields
  wire        retry_busy = ctl_a_r[CA_RETRY];
  wire        scope      = ctl_a_r[CA_SCOPE];
  wire        sr_dis     = ctl_a_r[CA_SRDIS];
  wire        idle_wait  = ctl_a_r[CA_IDLE];
  wire        auto_rsp   = ctl_a_r[CA_AUTO];
  wire [2:0]  tx_sop     = ctl_b_r[CB_SOP +: 3];
  wire        cbl_en     = ctl_b_r[CB_CBL];
  wire        expect_ack = ctl_b_r[CB_EXP];
  wire [2:0]  limit      = parm_c_r[PC_RETRY +: 3];
  wire        retry_ok   = auto_rsp & (limit != 3'h0);
  wire        retry_left = retry_ok & (cnt_r < limit);
  wire        pending    = state_r != ST_IDLE;

  assign queue_fifo_mode = ctl_a_r[CA_FIFO];
  assign raw_mode        = ctl_a_r[CA_RAW];

  ////////////////////////////////////////////////////////////////////////
  // abort sources
  wire rx_new   = rx_valid & rx_pkt.good & ~rx_pkt.dup & ~rx_pkt.ping & ~rx_pkt.goodcrc;
  wire rx_same  = rx_pkt.sop == tx_sop;
  wire rx_prim  = (rx_pkt.sop == SOP_PRIMARY) & (tx_sop != SOP_PRIMARY) & ~scope;
  wire rx_hit   = ~cur_ack_r & rx_new & (rx_same | rx_prim);
  wire cbl_hit  = ~cur_ack_r & cable_reset_rx & cbl_en & is_cable(tx_sop);
  wire abort_any = pending & (hard_reset_rx | cbl_hit | rx_hit | sw_abort);
  // soft-reset ack goes out even over a busy line unless disabled
  wire sr_special = cur_ack_r & cur_sr_r & ~sr_dis;

  ////////////////////////////////////////////////////////////////////////
  // transmit sequencer
  logic set_done, set_abrt, set_fail, start_pkt, take_ack, take_go;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    set_done  = 1'b0;
    set_abrt  = 1'b0;
    set_fail  = 1'b0;
    start_pkt = 1'b0;
    take_ack  = 1'b0;
    take_go   = 1'b0;
    if (abort_any) begin
      state_nxt = ST_IDLE;
      set_abrt  = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (ack_pend_r) begin
            take_ack  = 1'b1;
            cnt_nxt   = 3'h0;
            state_nxt = ST_ARB;
          end else if (go_pend_r) begin
            take_go   = 1'b1;
            cnt_nxt   = 3'h0;
            state_nxt = ST_ARB;
          end
        end
        ST_ARB: begin
          if (!line_busy || sr_special) begin
            start_pkt = 1'b1;
            state_nxt = ST_SEND;
          end else if (idle_wait) begin
            state_nxt = ST_WAIT;
          end else if (retry_busy && retry_ok) begin
            if (retry_left) begin
              cnt_nxt = cnt_r + 3'h1;
            end else begin
              set_fail  = 1'b1;
              state_nxt = ST_IDLE;
            end
          end else begin
            set_abrt  = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (!line_busy) begin
            start_pkt = 1'b1;
            state_nxt = ST_SEND;
          end
        end
        ST_SEND: begin
          if (phy_done) begin
            if (expect_ack && !cur_ack_r) begin
              state_nxt = ST_ACK;
            end else begin
              set_done  = 1'b1;
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (ack_rx) begin
            set_done  = 1'b1;
            state_nxt = ST_IDLE;
          end else if (ack_timeout) begin
            if (retry_left) begin
              cnt_nxt   = cnt_r + 3'h1;
              state_nxt = ST_ARB;
            end else begin
              set_fail  = 1'b1;
              state_nxt = ST_IDLE;
            end
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  assign tx_drive   = state_r == ST_SEND;
  assign tx_active  = pending;
  assign phy_start  = phy_start_r;
  assign phy_is_ack = cur_ack_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r     <= ST_IDLE;
      cnt_r       <= 3'h0;
      phy_start_r <= 1'b0;
      cur_ack_r   <= 1'b0;
      cur_sr_r    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      phy_start_r <= start_pkt;
      if (take_ack) begin
        cur_ack_r <= 1'b1;
        cur_sr_r  <= ack_sr_r;
      end else if (take_go) begin
        cur_ack_r <= 1'b0;
        cur_sr_r  <= 1'b0;
      end
    end
  end

  // requests: a new request in the taking cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      go_pend_r  <= 1'b0;
      ack_pend_r <= 1'b0;
      ack_sr_r   <= 1'b0;
    end else begin
      go_pend_r  <= sw_go | (go_pend_r & ~take_go & ~sw_abort);
      ack_pend_r <= (ack_req & auto_rsp) | (ack_pend_r & ~take_ack);
      if (ack_req && auto_rsp) begin
        ack_sr_r <= ack_for_soft_reset;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and interrupt
  wire [2:0] ev   = {set_fail, set_abrt, set_done};
  wire [2:0] w1c  = (wr_en & hit_is) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctl_a_r  <= CTL_A_RST;
      parm_c_r <= 8'h00;
      ctl_b_r  <= 8'h00;
      irq_st_r <= 3'h0;
      irq_mk_r <= 3'h0;
    end else begin
      if (wr_en && hit_a) begin
        ctl_a_r <= pwdata[7:0] & CTL_A_WMASK;
      end
      if (wr_en && hit_c) begin
        parm_c_r <= pwdata[7:0] & PARM_C_WMASK;
      end
      if (wr_b) begin
        ctl_b_r <= {1'b0, pwdata[CB_EXP], pwdata[CB_CBL], pwdata[CB_SOP +: 3], 2'b00};
      end
      if (wr_en && hit_im) begin
        irq_mk_r <= pwdata[2:0];
      end
      irq_st_r <= ev | (irq_st_r & ~w1c);
    end
  end

  assign irq = |(irq_st_r & irq_mk_r);

  // read data captured in the setup cycle; one access cycle, no wait
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata_r  <= 8'h00;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r  <= rd_mux;
      pslverr_r <= ~hit_any;
    end
  end

  assign prdata  = {24'h000000, prdata_r};
  assign pready  = 1'b1;
  assign pslverr = pslverr_r & psel & penable;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_busy_abort: assert property (
    state_r == ST_ARB && line_busy && !sr_special && !idle_wait && !retry_busy && !abort_any
    |=> state_r == ST_IDLE && irq_st_r[IQ_ABRT])
    else $error("busy line did not abort the packet");

  chk_busy_retry: assert property (
    state_r == ST_ARB && line_busy && !sr_special && !idle_wait && retry_busy && retry_left
    && !abort_any |=> state_r == ST_ARB && cnt_r == $past(cnt_r) + 3'h1)
    else $error("busy retry did not count");

  chk_fail_flag: assert property (
    state_r == ST_ARB && line_busy && !sr_special && !idle_wait && retry_busy && retry_ok
    && !retry_left && !abort_any |=> irq_st_r[IQ_FAIL] && state_r == ST_IDLE)
    else $error("exhausted retries did not report failure");

  chk_hard_reset: assert property (
    pending && hard_reset_rx |=> state_r == ST_IDLE ##0 irq_st_r[IQ_ABRT])
    else $error("hard reset did not abort");

  chk_rx_abort: assert property (
    pending && rx_hit |=> !tx_drive && irq_st_r[IQ_ABRT])
    else $error("received packet did not abort");

  chk_sw_abort: assert property (
    pending && sw_abort |=> state_r == ST_IDLE ##1 !tx_drive[*2])
    else $error("software abort ignored");

  chk_scope: assert property (
    pending && rx_valid && scope && rx_pkt.sop != tx_sop && !hard_reset_rx && !sw_abort
    && !cbl_hit |-> !abort_any)
    else $error("scoped abort fired on other type");

  chk_sr_ack: assert property (
    state_r == ST_ARB && sr_special && line_busy && !abort_any |=> tx_drive ##0 phy_start)
    else $error("soft reset ack blocked by busy line");

  chk_wait_idle: assert property (
    state_r == ST_ARB && line_busy && !sr_special && idle_wait && !abort_any
    |=> state_r == ST_WAIT && !tx_drive)
    else $error("idle wait not taken");

  chk_no_retry: assert property (
    state_r == ST_ACK && ack_timeout && !ack_rx && !auto_rsp && !abort_any
    |=> state_r == ST_IDLE && irq_st_r[IQ_FAIL])
    else $error("retry without auto reply");

  chk_ctl_reserved: assert property (
    !ctl_a_r[7] && (!prdata_r[7] || !$past(hit_a)))
    else $error("reserved bit set");

  cov_send: cover property (state_r == ST_SEND ##[1:50] set_done);
  cov_retry: cover property (state_r == ST_ARB && cnt_nxt != cnt_r);
  cov_abort: cover property (pending ##1 set_abrt);

endmodule

// ---- tb/pdtx_far_model.sv ----
/*
  pdtx_far_model: remote pd port and phy as seen by the tx policy block.
  assumes tb_top calls its tasks right after a rising edge of core_clk.
*/
`timescale 1ns/100ps
module pdtx_far_model
  import pdtx_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic tx_drive,
  output logic      line_busy,
  output logic      rx_valid,
  output pdtx_rx_t  rx_pkt,
  output logic      hard_reset_rx,
  output logic      cable_reset_rx,
  output logic      ack_req,
  output logic      ack_for_soft_reset,
  output logic      phy_done,
  output logic      ack_rx,
  output logic      ack_timeout
);
  int done_dly = 4;
  int cnt = 0;

  initial begin
    line_busy = 1'b0;
    rx_valid = 1'b0;
    rx_pkt = '0;
    hard_reset_rx = 1'b0;
    cable_reset_rx = 1'b0;
    ack_req = 1'b0;
    ack_for_soft_reset = 1'b0;
    phy_done = 1'b0;
    ack_rx = 1'b0;
    ack_timeout = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // the frame ends done_dly+2 cycles into the drive; an early stop never completes
  always @(posedge core_clk) begin
    phy_done <= 1'b0;
    if (srst || tx_drive !== 1'b1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
      if (cnt == done_dly) begin
        phy_done <= 1'b1;
      end
    end
  end

  task automatic set_busy(input logic b);
    line_busy <= b;
  endtask

  // kind 0 hard reset, 1 cable reset, 2 rx packet, 3 ack request
  task automatic fire(input int k, input logic [2:0] s);
    hard_reset_rx <= (k == 0);
    cable_reset_rx <= (k == 1);
    rx_valid <= (k == 2);
    rx_pkt <= '{sop: s, good: 1'b1, dup: 1'b0, ping: 1'b0, goodcrc: 1'b0};
    ack_req <= (k == 3);
    ack_for_soft_reset <= s[0];
    @(posedge core_clk);
    hard_reset_rx <= 1'b0;
    cable_reset_rx <= 1'b0;
    rx_valid <= 1'b0;
    ack_req <= 1'b0;
    // released qualifiers must not keep looking valid
    rx_pkt <= ~rx_pkt;
    ack_for_soft_reset <= ~ack_for_soft_reset;
  endtask
endmodule

// ---- tb/tb_top.sv ----
/*
  tb_top: self-checking bench of pdtx_ctrl against a rule model.
  assumes pdtx_pkg and the far-side model are compiled first.
*/
`timescale 1ns/100ps
module tb_top
  import pdtx_pkg::*;
  ();
  logic        core_clk, srst, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, rq;
  logic        pready, pslverr, re, line_busy, rx_valid, hard_reset_rx, cable_reset_rx;
  logic        ack_req, ack_for_soft_reset, phy_done, ack_rx, ack_timeout, phy_start;
  logic        phy_is_ack, tx_drive, tx_active, queue_fifo_mode, raw_mode, irq, seen;
  logic [7:0]  ca;
  logic [2:0]  msk;
  pdtx_rx_t    rx_pkt;
  int          fail_count = 0;
  int          compares = 0;
  int          cyc = 0;
  logic [7:0]  dca[6] = '{8'h00, 8'h08, 8'h48, 8'h44, 8'h40, 8'h44};
  int          dlm[6] = '{3, 3, 3, 3, 3, 0};
  int          ak[9] = '{0, 1, 1, 1, 2, 2, 2, 2, 3};
  int          asc[9] = '{0, 0, 0, 0, 0, 0, 1, 0, 0};
  int          ats[9] = '{0, 1, 0, 1, 0, 2, 2, 2, 3};
  int          ars[9] = '{0, 0, 0, 0, 0, 0, 0, 1, 0};
  int          acb[9] = '{0, 1, 1, 0, 0, 0, 0, 0, 0};
  logic [7:0]  kca[4] = '{8'h00, 8'h04, 8'h1c, 8'h14};

  pdtx_ctrl dut_u (.core_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .line_busy, .rx_valid, .rx_pkt, .hard_reset_rx, .cable_reset_rx,
    .ack_req, .ack_for_soft_reset, .phy_done, .ack_rx, .ack_timeout, .phy_start,
    .phy_is_ack, .tx_drive, .tx_active, .queue_fifo_mode, .raw_mode, .irq);
  pdtx_far_model far_u (.core_clk, .srst, .tx_drive, .line_busy, .rx_valid, .rx_pkt,
    .hard_reset_rx, .cable_reset_rx, .ack_req, .ack_for_soft_reset, .phy_done, .ack_rx,
    .ack_timeout);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  // w 0 waits on tx_active, 1 on tx_drive; bounded so a hang shows as a mismatch
  task automatic wait_for(input int w, input logic v);
    int n;
    n = 0;
    while (((w == 0) ? tx_active : tx_drive) !== v && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk(n < 300, 1'b1, "wait bound");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] tx_model(logic [7:0] a, int lim, logic bz);
    if (!bz || a[CA_IDLE]) return 32'h0000_0001;
    if (a[CA_RETRY] && a[CA_AUTO] && lim > 0) return 32'h0000_0004;
    return 32'h0000_0002;
  endfunction

  function automatic logic abort_model(int k, int sc, int ts, int rs, int cb);
    case (k)
      1: return cb != 0 && ts >= 1 && ts <= 4;
      2: return rs == ts || (rs == 0 && ts != 0 && sc == 0);
      default: return 1'b1;
    endcase
  endfunction

  task automatic run_tx(input logic [7:0] a, input int lim, input logic bz);
    wr(ADDR_CTL_A, {24'h0, a});
    wr(ADDR_PARM_C, {25'h0, lim[2:0], 4'h0});
    far_u.set_busy(bz);
    wr(ADDR_CTL_B, 32'h0000_0001);
    repeat (20) @(posedge core_clk);
    far_u.set_busy(1'b0);
    wait_for(0, 1'b0);
    chk(raw_mode, a[CA_RAW], "raw mode");
    chk(queue_fifo_mode, a[CA_FIFO], "fifo mode");
    apb(ADDR_IRQ_ST, 1'b0, 32'h0);
    chk(rq, tx_model(a, lim, bz), "tx outcome");
    chk(irq, |(tx_model(a, lim, bz) & msk), "irq level");
    wr(ADDR_IRQ_ST, 32'h0000_0007);
  endtask

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(51));
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    apb(ADDR_CTL_A, 1'b0, 32'h0);
    chk(rq, 32'h0000_0000, "ctl_a reset");
    ca = 8'($urandom);
    wr(ADDR_CTL_A, {24'h0, ca});
    apb(ADDR_CTL_A, 1'b0, 32'h0);
    chk(rq, {24'h0, ca & CTL_A_WMASK}, "ctl_a top bit");
    apb(32'h0000_0010, 1'b0, 32'h0);
    chk({rq[30:0], re}, 32'h0000_0001, "unmapped");
    wr(ADDR_IRQ_MK, 32'h0000_0007);
    msk = 3'h7;
    for (int i = 0; i < 6; i++) run_tx(dca[i], dlm[i], 1'b1);
    for (int i = 0; i < 12; i++) run_tx(8'($urandom) & 8'h7f, $urandom_range(0, 7),
      1'($urandom));
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_CTL_A, 32'(asc[i] << 5));
      far_u.done_dly = 30;
      wr(ADDR_CTL_B, 32'((acb[i] << 5) | (ats[i] << 2) | 1));
      wait_for(1, 1'b1);
      if (ak[i] == 3) wr(ADDR_CTL_B, 32'h0000_0002);
      else far_u.fire(ak[i], 3'(ars[i]));
      repeat (2) @(posedge core_clk);
      seen = abort_model(ak[i], asc[i], ats[i], ars[i], acb[i]);
      chk(tx_drive, !seen, "drive stop");
      wait_for(0, 1'b0);
      apb(ADDR_IRQ_ST, 1'b0, 32'h0);
      chk(rq, seen ? 32'h0000_0002 : 32'h0000_0001, "abort outcome");
      wr(ADDR_IRQ_ST, 32'h0000_0007);
    end
    far_u.done_dly = 4;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTL_A, {24'h0, kca[i]});
      far_u.set_busy(1'b1);
      far_u.fire(3, 3'h1);
      seen = 1'b0;
      repeat (10) begin
        @(posedge core_clk);
        if (phy_start === 1'b1 && phy_is_ack === 1'b1) seen = 1'b1;
      end
      chk(seen, kca[i][CA_AUTO] && !kca[i][CA_SRDIS], "soft reset ack");
      far_u.set_busy(1'b0);
      repeat (3) @(posedge core_clk);
      wait_for(0, 1'b0);
      wr(ADDR_IRQ_ST, 32'h0000_0007);
    end
    // masked event stays pending without raising the line
    wr(ADDR_IRQ_MK, 32'h0000_0000);
    msk = 3'h0;
    run_tx(8'h00, 0, 1'b0);
    wr(ADDR_IRQ_MK, 32'h0000_0001);
    chk(irq, 1'b0, "irq cleared");
    report_and_stop();
  end
endmodule
